/* shared/ptc_defs.vh */
// Constants of the page timing counters: clock rates, pulse widths, counts and decode points
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH

// System clock and master clock rates
`define PTC_CLK_KHZ        50000
`define PTC_MASTER_KHZ     3072
`define PTC_NCO_W          24
// Master clock tick increment, 64-bit because the product passes 2^31
`define PTC_NCO_INC        ((64'd3072 << 24) / 64'd50000)

// Timing clock pulse width and phase spacing, in nanoseconds
`define PTC_PULSE_NS       200
`define PTC_PHASE_GAP_NS   651
// Longest time rounds down: 200 ns at 50 MHz is 10 cycles
`define PTC_PULSE_CYC      ((`PTC_PULSE_NS * (`PTC_CLK_KHZ / 1000)) / 1000)

// Master clock divided by four gives the 768 KHz square wave
`define PTC_DIV_W          2
`define PTC_DIV_RISE       2'h1
`define PTC_DIV_FALL       2'h3
`define PTC_DIV_RST        2'h0

// Bit ring
`define PTC_RING_W         5
`define PTC_RING_RST       5'h00
`define PTC_BIT_TIMES      10

// Character counter
`define PTC_CHAR_W         6
`define PTC_CHAR_RST       6'h00
`define PTC_CHAR_BOL       6'h01
`define PTC_CHAR_BOP       6'h02
`define PTC_CHAR_EOL       6'h37
`define PTC_CHAR_EOP       6'h3a
`define PTC_CHAR_IO_PAGE_BEGIN_MARKER      6'h3f

// Line counter, decrementing from line 1 down to line 20
`define PTC_LINE_W         5
`define PTC_LINE_FIRST     5'h13
`define PTC_LINE_LAST      5'h00
`define PTC_LINE_CENTER    5'h0a

`endif

/* rtl/ptc_phase_gen.v */
// Master clock tick, divide-by-four square wave and the two timing clock phases
`include "ptc_defs.vh"

module ptc_phase_gen (
  input  wire clock,          // 50 MHz system clock
  input  wire arst_n,         // Asynchronous reset, active low
  input  wire freeze,         // Stops the master clock during the resync hold
  output reg  phase_a_en,     // One-cycle enable on square wave rise
  output reg  phase_b_en,     // One-cycle enable on square wave fall
  output reg  phase_a_clock,  // 200 ns phase A pulse
  output reg  phase_b_clock,  // 200 ns phase B pulse
  output reg  square_wave     // 768 KHz square wave
);

  localparam [63:0] INC_FULL = `PTC_NCO_INC;

  wire [`PTC_NCO_W-1:0] inc = INC_FULL[`PTC_NCO_W-1:0];
  reg  [`PTC_NCO_W-1:0] acc_q;
  reg  [`PTC_DIV_W-1:0] div_q;
  reg  [3:0]            a_cnt_q;
  reg  [3:0]            b_cnt_q;
  wire [`PTC_NCO_W:0]   sum = {1'b0, acc_q} + {1'b0, inc};
  wire                  tick = sum[`PTC_NCO_W] & ~freeze;

  // Fractional accumulator makes the 3.072 MHz master tick; freeze holds it still
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= {`PTC_NCO_W{1'b0}};
      div_q <= `PTC_DIV_RST;
    end else if (!freeze) begin
      acc_q <= sum[`PTC_NCO_W-1:0];
      if (tick) begin
        div_q <= div_q + 2'h1;  // see [RULE22]
      end
    end
  end

  // Enables fire on rise and fall of the divided wave, half a bit period apart
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_a_en  <= 1'b0;
      phase_b_en  <= 1'b0;
      square_wave <= 1'b0;
    end else begin
      phase_a_en  <= tick & (div_q == `PTC_DIV_RISE);  // see [RULE2] see [RULE23]
      phase_b_en  <= tick & (div_q == `PTC_DIV_FALL);  // see [RULE2] see [RULE23]
      square_wave <= div_q[1];
    end
  end

  // Stretch each enable to a fixed-width pulse; 10 cycles never reach the other phase
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      a_cnt_q       <= 4'h0;
      b_cnt_q       <= 4'h0;
      phase_a_clock <= 1'b0;
      phase_b_clock <= 1'b0;
    end else begin
      if (phase_a_en) begin
        a_cnt_q       <= 4'h1;
        phase_a_clock <= 1'b1;  // see [RULE1]
      end else if (phase_a_clock) begin
        a_cnt_q       <= a_cnt_q + 4'h1;
        phase_a_clock <= (a_cnt_q < `PTC_PULSE_CYC);
      end
      if (phase_b_en) begin
        b_cnt_q       <= 4'h1;
        phase_b_clock <= 1'b1;  // see [RULE1]
      end else if (phase_b_clock) begin
        b_cnt_q       <= b_cnt_q + 4'h1;
        phase_b_clock <= (b_cnt_q < `PTC_PULSE_CYC);
      end
    end
  end

endmodule

/* rtl/ptc_bit_ring.v */
// Self-correcting five-stage bit ring, phase B bit flop and bit time decode
`include "ptc_defs.vh"

module ptc_bit_ring (
  input  wire       clock,             // 50 MHz system clock
  input  wire       arst_n,            // Asynchronous reset, active low
  input  wire       mclr,              // Synchronised master clear
  input  wire       phase_a_en,        // Phase A enable
  input  wire       phase_b_en,        // Phase B enable
  output reg  [4:0] bit_ring_stages,   // Stage 1 in bit 0
  output reg        phase_b_bit_flop,  // Set by phase A, cleared by phase B
  output reg  [9:0] bit_time_a,        // Bit time n in bit n-1, phase A
  output reg  [9:0] bit_time_b         // Bit time n in bit n-1, phase B
);

  reg  [4:0] fixed;
  reg  [9:0] dec;
  integer    k;

  // Stages 4,5 at 01 clear stages 1,2 before the shift; harmless at count 10
  always @* begin
    fixed = bit_ring_stages;
    if (!bit_ring_stages[3] && bit_ring_stages[4]) begin
      fixed[1:0] = 2'h0;  // see [RULE6]
    end
  end

  // Walking code decode of the ten counts
  always @* begin
    dec = 10'h000;
    dec[0] = ~bit_ring_stages[0] & ~bit_ring_stages[4];  // see [RULE7]
    dec[5] = bit_ring_stages[0] & bit_ring_stages[4];
    for (k = 1; k < 5; k = k + 1) begin
      dec[k]     = bit_ring_stages[k-1] & ~bit_ring_stages[k];
      dec[k + 5] = ~bit_ring_stages[k-1] & bit_ring_stages[k];
    end
  end

  // Ring shifts on phase A; stages 1-4 pass to the next higher stage, stage 5 returns inverted to stage 1
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bit_ring_stages <= `PTC_RING_RST;
    end else if (mclr) begin
      bit_ring_stages <= `PTC_RING_RST;  // see [RULE5] see [RULE24]
    end else if (phase_a_en) begin
      bit_ring_stages <= {fixed[3:0], ~fixed[4]};  // see [RULE3] see [RULE4]
    end
  end

  // B flop only arms after an A pulse, so B strobes never run ahead of the ring
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_b_bit_flop <= 1'b0;
    end else if (mclr) begin
      phase_b_bit_flop <= 1'b0;  // see [RULE24]
    end else if (phase_b_en) begin
      phase_b_bit_flop <= 1'b0;  // see [RULE8]
    end else if (phase_a_en) begin
      phase_b_bit_flop <= 1'b1;
    end
  end

  // A strobe n: ring holds count n; B strobe n: ring has already moved to n+1
  always @* begin
    bit_time_a = dec & {10{phase_a_en}};  // see [RULE7]
    bit_time_b = {dec[0], dec[9:1]} & {10{phase_b_en & phase_b_bit_flop}};  // see [RULE8]
  end

endmodule

/* rtl/ptc_page_timing.v */
// Page timing chain: clock phases, bit ring, character and line counters, markers, resync
// Function
// [RULE1] Two non-overlapping 200 ns phase pulses per bit, B follows A by 651 ns.
// [RULE2] Phase A on square wave rise, phase B on fall, 1.302 us bit.
// [RULE3] Bit ring of five stages advances on phase A toward higher stages.
// [RULE4] Ring walks ten states: zeros, fill with ones, then fill with zeros.
// [RULE5] Ring start state is made by clearing its first two stages. The code clears all five stages on master clear.
// [RULE6] Stages 4,5 at 01 force stages 1,2 to zero, self-correcting.
// [RULE7] Phase A bit time strobes are AND decodes of ring stages.
// [RULE8] Phase B flop plus ring decode give B strobes 651 ns after A.
// [RULE9] Character counter trigger fires once per character at bit time 4A.
// [RULE10] Display strobe at 1A and 10B, sweep gate at 1A and 2A.
// [RULE11] Six-bit binary character counter, 64 positions, steps on the trigger.
// [RULE12] Character and line counts form line, page, sync markers.
// [RULE13] Line end pulse is count 55 with bit time 10B; it steps lines.
// [RULE14] Line counter is five stages, decrementing, covering 20 lines.
// [RULE15] Half-page loop output marks lines 10 and 20 for center-or-end.
// [RULE16] Last-line output forms page end, page begin and vertical sync.
// [RULE17] A page spans 1280 character times: 1080 shown plus 200 flyback.
// [RULE18] Serial store data is return-to-zero: pulse for one, none for zero.
// [RULE19] Timing chain resynchronises to stored sync bits after every page.
// [RULE20] Hold freezes master clock and counters until the second sync pulse.
// [RULE21] Start flag stays set until count 63 after resync completes.
// [RULE22] The square wave is the master clock divided down.
// [RULE23] Phases are single-cycle enables of one fast clock driving all counters.
// [RULE24] Master clear resets bit, character, line counters and the B flop.
`include "ptc_defs.vh"

module ptc_page_timing (
  input  wire       clock,                 // 50 MHz system clock
  input  wire       arst_n,                // Asynchronous reset, active low
  input  wire       master_clear_pin,      // Master clear from pin, active high
  input  wire       stored_sync_pin,       // Sync bit detected at store output
  input  wire       store_bit,             // Serial bit to recirculate, same clock
  output wire       phase_a_clock,         // 200 ns phase A timing clock
  output wire       phase_b_clock,         // 200 ns phase B timing clock
  output wire       square_wave,           // 768 KHz divided master clock
  output wire [4:0] bit_ring_stages,       // Bit ring stages, stage 1 in bit 0
  output wire       phase_b_bit_flop,      // Phase B bit flop
  output wire [9:0] bit_time_a_strobe,     // Phase A bit times 1..10
  output wire [9:0] bit_time_b_strobe,     // Phase B bit times 1..10
  output wire       char_count_trigger,    // Once per character at 4A
  output wire       char_pulse,            // Once per character at 1A
  output wire       display_reg_strobe,    // At 1A and 10B
  output wire       char_sweep_gate,       // At 1A and 2A
  output reg  [5:0] char_position_count,   // Character position 0..63
  output reg  [4:0] line_count_stages,     // Line counter, 19 down to 0
  output wire       last_line_marker,      // Level on the last line
  output wire       half_page_loop,        // Level on lines 10 and 20
  output wire       line_begin_marker,     // Level at character 1
  output wire       line_end_pulse,        // Pulse: count 55 at 10B
  output wire       page_begin_marker,     // Level: last line, character 2
  output wire       io_page_begin_marker,  // Level: last line, character 63
  output wire       center_or_page_end,    // Pulse: line end on line 10 or 20
  output wire       page_end_marker,       // Level: last line, character 58
  output wire       vertical_sync,         // Level on the last line
  output wire       horizontal_sync,       // Level from character 56 to 63
  output wire       hold_active,           // Counters frozen awaiting sync
  output wire       wait_active,           // Awaiting first sync pulse
  output reg        start_flag,            // Start flag
  output reg        store_rz_pulse         // Return-to-zero serial data
);

  // Resync states
  localparam [2:0] ST_RUN  = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_HOLD = 3'b100;

  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg        mclr_s1_q;
  reg        mclr_s2_q;
  reg        sync_s1_q;
  reg        sync_s2_q;
  reg        sync_s3_q;
  wire       sync_rise;
  wire       freeze;
  wire       phase_a_en;
  wire       phase_b_en;

  // Two-stage synchronisers; the sync pin adds a third stage, and its second and third stages feed the rise detect
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mclr_s1_q <= 1'b0;
      mclr_s2_q <= 1'b0;
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      sync_s3_q <= 1'b0;
    end else begin
      mclr_s1_q <= master_clear_pin;
      mclr_s2_q <= mclr_s1_q;
      sync_s1_q <= stored_sync_pin;
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
    end
  end

  assign sync_rise = sync_s2_q & ~sync_s3_q;

  // Hold stops the master clock itself, so every counter freezes with it
  assign freeze = state_q[2];  // see [RULE20]

  ptc_phase_gen u_phase (
    .clock         (clock),
    .arst_n        (arst_n),
    .freeze        (freeze),
    .phase_a_en    (phase_a_en),
    .phase_b_en    (phase_b_en),
    .phase_a_clock (phase_a_clock),
    .phase_b_clock (phase_b_clock),
    .square_wave   (square_wave)
  );

  ptc_bit_ring u_ring (
    .clock            (clock),
    .arst_n           (arst_n),
    .mclr             (mclr_s2_q),
    .phase_a_en       (phase_a_en),
    .phase_b_en       (phase_b_en),
    .bit_ring_stages  (bit_ring_stages),
    .phase_b_bit_flop (phase_b_bit_flop),
    .bit_time_a       (bit_time_a_strobe),
    .bit_time_b       (bit_time_b_strobe)
  );

  // Per-character strobes from the bit times
  assign char_count_trigger = bit_time_a_strobe[3];                         // see [RULE9]
  assign char_pulse         = bit_time_a_strobe[0];
  assign display_reg_strobe = bit_time_a_strobe[0] | bit_time_b_strobe[9];  // see [RULE10]
  assign char_sweep_gate    = bit_time_a_strobe[0] | bit_time_a_strobe[1];  // see [RULE10]

  // Line end: character 55 coinciding with bit time 10B
  assign line_end_pulse = (char_position_count == `PTC_CHAR_EOL) & bit_time_b_strobe[9];  // see [RULE13]

  // Character counter wraps naturally at 64; 20 lines of 64 give 1280 character times
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      char_position_count <= `PTC_CHAR_RST;
    end else if (mclr_s2_q) begin
      char_position_count <= `PTC_CHAR_RST;  // see [RULE24]
    end else if (char_count_trigger) begin
      char_position_count <= char_position_count + 6'h01;  // see [RULE11] see [RULE17]
    end
  end

  // Decrementing line counter; reload after the last line stands in for the selective reset
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      line_count_stages <= `PTC_LINE_FIRST;
    end else if (mclr_s2_q) begin
      line_count_stages <= `PTC_LINE_FIRST;  // see [RULE24]
    end else if (line_end_pulse) begin
      if (line_count_stages == `PTC_LINE_LAST) begin
        line_count_stages <= `PTC_LINE_FIRST;  // see [RULE14]
      end else begin
        line_count_stages <= line_count_stages - 5'h01;  // see [RULE14]
      end
    end
  end

  // Line counter outputs
  assign last_line_marker = (line_count_stages == `PTC_LINE_LAST);  // see [RULE16]
  assign half_page_loop   = (line_count_stages == `PTC_LINE_CENTER) | last_line_marker;  // see [RULE15]

  // Markers from character position and line state
  assign line_begin_marker    = (char_position_count == `PTC_CHAR_BOL);  // see [RULE12]
  assign page_begin_marker    = last_line_marker & (char_position_count == `PTC_CHAR_BOP);
  assign io_page_begin_marker = last_line_marker & (char_position_count == `PTC_CHAR_IO_PAGE_BEGIN_MARKER);
  assign page_end_marker      = last_line_marker & (char_position_count == `PTC_CHAR_EOP);
  assign center_or_page_end   = half_page_loop & line_end_pulse;  // see [RULE15]
  assign vertical_sync        = last_line_marker;  // see [RULE16]
  assign horizontal_sync      = (char_position_count > `PTC_CHAR_EOL);  // see [RULE12]

  // Resync: wait after each page for the stored sync pair, hold between the two pulses
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (last_line_marker && line_end_pulse) begin
          state_d = ST_WAIT;  // see [RULE19]
        end
      end
      ST_WAIT: begin
        if (sync_rise) begin
          state_d = ST_HOLD;  // see [RULE20]
        end
      end
      ST_HOLD: begin
        if (sync_rise) begin
          state_d = ST_RUN;  // see [RULE20]
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // Master clear abandons any resync so that the counters run to lay down sync bits
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_RUN;
    end else if (mclr_s2_q) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  assign wait_active = state_q[1];
  assign hold_active = state_q[2];

  // Start flag: set by master clear, cleared at character 63 of the last line only once running again
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      start_flag <= 1'b1;
    end else if (mclr_s2_q) begin
      start_flag <= 1'b1;
    end else if (state_q[0] && io_page_begin_marker && char_count_trigger) begin
      start_flag <= 1'b0;  // see [RULE21]
    end
  end

  // Return-to-zero: a one rides the phase A pulse, a zero leaves the line low
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      store_rz_pulse <= 1'b0;
    end else begin
      store_rz_pulse <= store_bit & phase_a_clock;  // see [RULE18]
    end
  end

endmodule

/* test/ptc_page_timing_monitor.sv */
// Concurrent checks on the ports of the page timing chain
module ptc_page_timing_monitor (
  input wire logic       clock,                // System clock
  input wire logic       arst_n,               // Asynchronous reset, active low
  input wire logic       master_clear_pin,     // Master clear pin
  input wire logic       store_bit,            // Serial bit to the store
  input wire logic       phase_a_clock,        // Phase A timing clock
  input wire logic       phase_b_clock,        // Phase B timing clock
  input wire logic       square_wave,          // Divided master clock
  input wire logic [4:0] bit_ring_stages,      // Bit ring
  input wire logic [9:0] bit_time_a_strobe,    // Phase A bit times
  input wire logic [9:0] bit_time_b_strobe,    // Phase B bit times
  input wire logic       char_count_trigger,   // Character trigger
  input wire logic [5:0] char_position_count,  // Character count
  input wire logic [4:0] line_count_stages,    // Line count
  input wire logic       last_line_marker,     // Last line level
  input wire logic       line_end_pulse,       // Line end pulse
  input wire logic       horizontal_sync,      // Horizontal sync level
  input wire logic       hold_active,          // Frozen for resync
  input wire logic       store_rz_pulse        // Return-to-zero data
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // Pulse shape of phase A and spacing of the two phases; the gap range allows the tick jitter of the divider
  chk_a_width: assert property ($rose(phase_a_clock) |-> phase_a_clock [*8] ##1 phase_a_clock
    ##1 phase_a_clock ##1 !phase_a_clock)
    else $error("phase A pulse is not ten cycles wide");
  chk_no_overlap: assert property (!(phase_a_clock && phase_b_clock))
    else $error("phase pulses overlap");
  chk_b_spacing: assert property ($rose(phase_a_clock) && !hold_active |-> ##[31:34] $rose(phase_b_clock))
    else $error("phase B did not follow phase A in time");
  // The A strobe is the cycle before the registered A clock and square wave rise together
  chk_a_on_rise: assert property (|bit_time_a_strobe |=> $rose(phase_a_clock) && square_wave)
    else $error("phase A strobe away from the square wave rise");
  // Ring moves toward higher stages, and the 01 pattern in stages 4,5 clears stages 1,2
  chk_ring_shift: assert property (|bit_time_a_strobe && !master_clear_pin
    |=> bit_ring_stages[4:3] == $past(bit_ring_stages[3:2]))
    else $error("bit ring did not shift");
  chk_ring_fix: assert property (|bit_time_a_strobe && !master_clear_pin && bit_ring_stages[4:3] == 2'b10
    |=> bit_ring_stages[2:1] == 2'b00)
    else $error("bit ring did not correct itself");
  chk_trigger_pos: assert property (char_count_trigger |-> bit_ring_stages == 5'h07
    && bit_time_a_strobe == 10'h008)
    else $error("character trigger away from bit time 4A");
  chk_char_step: assert property (char_count_trigger && !master_clear_pin
    |=> char_position_count == $past(char_position_count) + 6'h01)
    else $error("character count did not step by one");
  chk_line_end: assert property (line_end_pulse && !last_line_marker && !master_clear_pin
    |-> char_position_count == 6'h37 && bit_time_b_strobe[9]
    ##1 line_count_stages == $past(line_count_stages) - 5'h01)
    else $error("line end pulse or line step wrong");
  chk_hsync: assert property (horizontal_sync == (char_position_count >= 6'h38))
    else $error("horizontal sync span wrong");
  chk_rz_data: assert property (store_rz_pulse == $past(store_bit && phase_a_clock))
    else $error("store data is not return-to-zero");
endmodule

bind ptc_page_timing ptc_page_timing_monitor u_mon (.clock, .arst_n, .master_clear_pin, .store_bit, .phase_a_clock,
  .phase_b_clock, .square_wave, .bit_ring_stages, .bit_time_a_strobe, .bit_time_b_strobe, .char_count_trigger,
  .char_position_count, .line_count_stages, .last_line_marker, .line_end_pulse, .horizontal_sync, .hold_active,
  .store_rz_pulse);

/* test/ptc_store_model.sv */
// Behavioural model of the recirculating store that feeds the timing chain
module ptc_store_model (
  input  wire logic       clock,           // System clock
  input  wire logic       phase_a_clock,   // Bit clock from the chain
  input  wire logic [9:0] word,            // Character word to recirculate
  input  wire logic       sync_req,        // Ask for one stored sync bit
  output logic            store_bit,       // Serial bit back to the chain
  output logic            stored_sync_pin  // Detected sync bit, 20 cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idx_q      = 4'h0;
  logic       pa_q       = 1'b0;
  logic       req_q      = 1'b0;
  logic [4:0] sync_cnt_q = 5'h00;

  // Step to the next bit as the A pulse ends, so the bit stays steady through the whole pulse
  always @(posedge clock) begin
    pa_q  <= phase_a_clock;
    req_q <= sync_req;
    if (pa_q && !phase_a_clock)
      idx_q <= (idx_q == 4'h9) ? 4'h0 : idx_q + 4'h1;
    if (sync_req && !req_q)
      sync_cnt_q <= 5'h14;
    else if (sync_cnt_q != 5'h00)
      sync_cnt_q <= sync_cnt_q - 5'h01;
  end

  assign store_bit       = word[idx_q];
  assign stored_sync_pin = (sync_cnt_q != 5'h00);
endmodule

/* test/tb.sv */
// Self-checking testbench of the page timing chain
`include "ptc_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock            = 1'b0;
  logic       arst_n           = 1'b0;
  logic       master_clear_pin = 1'b0;
  logic       sync_req         = 1'b0;
  logic [9:0] store_word       = 10'h2a5;
  int         error_cnt        = 0;
  int         n_compared       = 0;
  wire        store_bit, stored_sync_pin, phase_a_clock, phase_b_clock, square_wave, phase_b_bit_flop;
  wire        char_count_trigger, char_pulse, display_reg_strobe, char_sweep_gate, last_line_marker;
  wire        half_page_loop, line_begin_marker, line_end_pulse, page_begin_marker, io_page_begin_marker;
  wire        center_or_page_end, page_end_marker, vertical_sync, horizontal_sync;
  wire        hold_active, wait_active, start_flag, store_rz_pulse;
  wire [4:0]  bit_ring_stages, line_count_stages;
  wire [9:0]  bit_time_a_strobe, bit_time_b_strobe;
  wire [5:0]  char_position_count;
  logic [4:0] ring_exp [10] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f, 5'h1e, 5'h1c, 5'h18, 5'h10};

  ptc_page_timing dut (.clock, .arst_n, .master_clear_pin, .stored_sync_pin, .store_bit, .phase_a_clock,
    .phase_b_clock, .square_wave, .bit_ring_stages, .phase_b_bit_flop, .bit_time_a_strobe, .bit_time_b_strobe,
    .char_count_trigger, .char_pulse, .display_reg_strobe, .char_sweep_gate, .char_position_count,
    .line_count_stages, .last_line_marker, .half_page_loop, .line_begin_marker, .line_end_pulse,
    .page_begin_marker, .io_page_begin_marker, .center_or_page_end, .page_end_marker, .vertical_sync,
    .horizontal_sync, .hold_active, .wait_active, .start_flag, .store_rz_pulse);
  ptc_store_model u_store (.clock, .phase_a_clock, .word(store_word), .sync_req, .store_bit, .stored_sync_pin);

  initial forever #10 clock = ~clock;

  // Look one nanosecond after the edge so the edge's updates have landed
  task automatic step(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // Bounded waits for the next strobe of each phase; k returns the cycles waited
  task automatic next_a(output int k);
    k = 0;
    do begin step(); k++; end while (bit_time_a_strobe === 10'h000 && k < 300);
  endtask

  task automatic next_b(output int k);
    k = 0;
    do begin step(); k++; end while (bit_time_b_strobe === 10'h000 && k < 300);
  endtask

  // The A and B clocks rise one cycle after their strobes
  task automatic t_phases;
    int g, p;
    next_a(p);
    step();
    cmp(phase_a_clock & square_wave, 1'b1, "A on square rise");
    step(9);
    cmp(phase_a_clock, 1'b1, "A still high");
    step();
    cmp(phase_a_clock, 1'b0, "A width");
    next_b(g);
    cmp(g + 11 >= 31 && g + 11 <= 34, 1'b1, "A to B spacing");
    step();
    cmp({phase_b_clock, square_wave}, 2'b10, "B on square fall");
    next_a(p);
    cmp(p + g + 12 >= 64 && p + g + 12 <= 66, 1'b1, "bit period");
    $display("t_phases done");
  endtask

  // Master clear, then walk one whole character of bit times
  task automatic t_clear_ring;
    int k;
    @(posedge clock) master_clear_pin <= 1'b1;
    step(4);
    cmp({bit_ring_stages, phase_b_bit_flop}, 6'h00, "ring and B flop cleared");
    cmp({char_position_count, line_count_stages}, {6'h00, `PTC_LINE_FIRST}, "counts cleared");
    next_a(k);
    @(posedge clock) master_clear_pin <= 1'b0;
    for (int n = 1; n <= 10; n++) begin
      next_a(k);
      cmp(bit_time_a_strobe, 10'h001 << (n - 1), "A bit time");
      cmp(bit_ring_stages, ring_exp[n - 1], "ring state");
      cmp(char_count_trigger, n == 4, "char trigger");
      cmp({char_pulse, display_reg_strobe, char_sweep_gate}, {n == 1, n == 1, n <= 2}, "A strobes");
      next_b(k);
      cmp(bit_time_b_strobe, 10'h001 << (n - 1), "B bit time");
      cmp(display_reg_strobe, n == 10, "display strobe at 10B");
    end
    cmp({char_position_count, line_begin_marker}, {6'h01, 1'b1}, "one char counted");
    $display("t_clear_ring done");
  endtask

  // Run to the end of the first line, across hsync and the wrap of the character count
  task automatic t_line;
    int k;
    for (k = 0; k < 40000 && line_end_pulse !== 1'b1; k++) step();
    cmp({char_position_count, bit_time_b_strobe[9]}, {`PTC_CHAR_EOL, 1'b1}, "line end point");
    cmp({center_or_page_end, half_page_loop, horizontal_sync}, 3'h0, "no marks on line 1");
    step();
    cmp(line_count_stages, `PTC_LINE_FIRST - 5'h01, "line stepped down");
    for (k = 0; k < 1000 && char_position_count !== 6'h38; k++) step();
    cmp(horizontal_sync, 1'b1, "hsync from 56");
    for (k = 0; k < 6000 && char_position_count !== 6'h00; k++) step();
    cmp({char_position_count, horizontal_sync}, 7'h00, "count wrapped");
    cmp({last_line_marker, vertical_sync, page_begin_marker, io_page_begin_marker, page_end_marker}, 5'h00,
        "no page marks on line 2");
    $display("t_line done");
  endtask

  // Ten bits of a word with five ones give fifty cycles of pulse
  task automatic t_rz;
    int k, sum;
    sum = 0;
    for (int n = 0; n < 10; n++) begin
      next_a(k);
      repeat (12) begin step(); sum += store_rz_pulse; end
    end
    cmp(sum, 16'd50, "return-to-zero pulse cycles");
    $display("t_rz done");
  endtask

  // Sync bits mid-page must not freeze the counters
  task automatic t_sync;
    int k;
    repeat (2) begin
      @(posedge clock) sync_req <= 1'b1;
      step(30);
      @(posedge clock) sync_req <= 1'b0;
      step(30);
    end
    cmp({wait_active, hold_active, start_flag}, 3'h1, "no resync mid-page");
    next_a(k);
    next_a(k);
    cmp(k <= 66, 1'b1, "counters still run");
    $display("t_sync done");
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog at twice the forty-odd thousand cycles the tests need
  initial begin
    #(90000 * 20);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    step(2);
    cmp({start_flag, line_count_stages}, {1'b1, `PTC_LINE_FIRST}, "state after reset");
    t_phases();
    t_clear_ring();
    t_rz();
    t_sync();
    t_line();
    finish_test();
  end
endmodule
